/* src/aucrr_pick.sv */
`timescale 1ns/1ps
`default_nettype none
// lowest enabled channel at or above a start index
module aucrr_pick
    import aucrr_pkg::*;
#(
    parameter int N = NCH
) (
    input wire logic [N-1:0] en,
    input wire logic [CW-1:0] from,
    output logic found,
    output logic [CW-1:0] idx
);
    // ------------------------------------------------------------
    // priority search
    // ------------------------------------------------------------
    // scan downward so the lowest match is written last
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (en[i] && (CW'(i) >= from)) begin
                found = 1'b1;
                idx = CW'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* src/aucrr_pkg.sv */
package aucrr_pkg;
    // ------------------------------------------------------------
    // channel order of the round-robin
    // ------------------------------------------------------------
    localparam int NCH = 21;
    localparam int CW = 5;
    localparam int NPIN = 6;
    localparam logic [CW-1:0] CH_CELL = 5'h00;
    localparam logic [CW-1:0] CH_STACK = 5'h01;
    localparam logic [CW-1:0] CH_PIN1 = 5'h05;
    // internal channels enabled through the two extra enable registers
    localparam int INT_A_CH [8] = '{2, 3, 4, 11, 12, 13, 14, 15};
    localparam int INT_B_CH [5] = '{16, 17, 18, 19, 20};

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CHCTL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_DIAG2 = 8'h02;
    localparam logic [7:0] ADDR_DIAG4 = 8'h03;
    localparam logic [7:0] ADDR_PINMODE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_TWOFS = 8'h06;
    localparam logic [7:0] ADDR_INTEN_A = 8'h07;
    localparam logic [7:0] ADDR_INTEN_B = 8'h08;
    localparam logic [7:0] ADDR_RES_BASE = 8'h20;
    localparam logic [7:0] ADDR_UNC_BASE = 8'h60;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CHCTL1_STACK_BIT = 0;
    localparam int CHCTL1_PIN_LSB = 1;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_TREF_BIT = 1;
    localparam int DIAG2_SEL_LSB = 0;
    localparam int DIAG2_SEL_EN_BIT = 3;
    localparam int DIAG4_FILT_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] DIAG_HI = 8'h80;
    localparam logic [7:0] DIAG_LO = 8'h00;
    localparam logic [2:0] CELL_MIN = 3'h1;
    localparam logic [2:0] CELL_MAX = 3'h6;

    // ------------------------------------------------------------
    // weight of one two's-complement count, for the host
    // ------------------------------------------------------------
    localparam real LSB_BASE_UV = 190.7349;
    localparam real LSB_CELL_UV = 2.0 * LSB_BASE_UV;
    localparam real LSB_STACK_MV = 2.827;
    localparam real LSB_ASUP_UV = 381.622;
    localparam real LSB_CSUP_UV = 548.47;
    localparam real LSB_PIN1_RAW_UV = 0.745;
    localparam real LSB_RATIO_PCT = 0.00007628;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aucrr_bus_s;

    typedef struct packed {
        logic [15:0] corr;
        logic [23:0] raw;
        logic [23:0] filt;
    } aucrr_adc_s;
endpackage

/* src/aucrr_slot.sv */
`timescale 1ns/1ps
`default_nettype none
// one result: live value plus a shadow of the lower bytes
module aucrr_slot
    import aucrr_pkg::*;
#(
    parameter int NB = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [NB*8-1:0] din,
    input wire logic hi_rd,
    output logic [7:0] hi,
    output logic [NB*8-9:0] lo
);
    logic [NB*8-1:0] live_r, live_nxt;
    logic [NB*8-9:0] shad_r, shad_nxt;

    // ------------------------------------------------------------
    // capture and lock
    // ------------------------------------------------------------
    // the shadow only follows on a high-byte read, so a conversion
    // landing mid-read cannot split the value
    always_comb begin
        live_nxt = wr ? din : live_r;
        shad_nxt = hi_rd ? live_r[NB*8-9:0] : shad_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_r <= {DIAG_HI, {(NB*8-8){1'b0}}};
            shad_r <= '0;
        end else begin
            live_r <= live_nxt;
            shad_r <= shad_nxt;
        end
    end

    assign hi = live_r[NB*8-1:NB*8-8];
    assign lo = shad_r;
endmodule
`default_nettype wire

/* src/aucrr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module aucrr_top
    import aucrr_pkg::*;
#(
    parameter logic [7:0] TWARN_OFFSET = 8'h00
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire aucrr_bus_s BUS,
    output logic [7:0] RDATA,
    output logic ADC_START,
    output logic [CW-1:0] ADC_CHAN,
    input wire logic ADC_DONE,
    input wire aucrr_adc_s ADC_RES,
    output logic [2:0] CELL_ROUTE,
    output logic CELL_ROUTE_EN,
    output logic WINDOW_CMP_PAUSE,
    output logic [NPIN-1:0] MEAS_RATIO,
    output logic TREF_ENABLE,
    output logic AUX_BUSY,
    output logic AUX_READY
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_q1, rst_n;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] chctl1_r, chctl1_nxt, diag2_r, diag2_nxt;
    logic [7:0] diag4_r, diag4_nxt, pinmode_r, pinmode_nxt;
    logic [7:0] inta_r, inta_nxt, intb_r, intb_nxt;
    logic tref_r, tref_nxt, route_en_r, route_en_nxt;
    logic go;
    logic [2:0] cell_sel;

    assign go = BUS.wr && (BUS.addr == ADDR_CTRL) && BUS.wdata[CTRL_GO_BIT];
    assign cell_sel = diag2_r[DIAG2_SEL_LSB +: 3];

    // software writes; the go bit is a strobe and is never stored
    always_comb begin
        chctl1_nxt = chctl1_r;
        diag2_nxt = diag2_r;
        diag4_nxt = diag4_r;
        pinmode_nxt = pinmode_r;
        inta_nxt = inta_r;
        intb_nxt = intb_r;
        tref_nxt = tref_r;
        if (BUS.wr) begin
            case (BUS.addr)
                ADDR_CHCTL1: chctl1_nxt = {1'b0, BUS.wdata[6:0]};
                ADDR_CTRL: tref_nxt = BUS.wdata[CTRL_TREF_BIT];
                ADDR_DIAG2: diag2_nxt = {4'h0, BUS.wdata[3:0]};
                ADDR_DIAG4: diag4_nxt = {7'h00, BUS.wdata[0]};
                ADDR_PINMODE: pinmode_nxt = {2'h0, BUS.wdata[5:0]};
                ADDR_INTEN_A: inta_nxt = BUS.wdata;
                ADDR_INTEN_B: intb_nxt = {3'h0, BUS.wdata[4:0]};
                default: ;
            endcase
        end
        // out-of-range cell codes route nothing
        route_en_nxt = diag2_nxt[DIAG2_SEL_EN_BIT]
            && (diag2_nxt[2:0] >= CELL_MIN)
            && (diag2_nxt[2:0] <= CELL_MAX);
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            chctl1_r <= RST_BYTE;
            diag2_r <= RST_BYTE;
            diag4_r <= RST_BYTE;
            pinmode_r <= RST_BYTE;
            inta_r <= RST_BYTE;
            intb_r <= RST_BYTE;
            tref_r <= 1'b0;
            route_en_r <= 1'b0;
        end else begin
            chctl1_r <= chctl1_nxt;
            diag2_r <= diag2_nxt;
            diag4_r <= diag4_nxt;
            pinmode_r <= pinmode_nxt;
            inta_r <= inta_nxt;
            intb_r <= intb_nxt;
            tref_r <= tref_nxt;
            route_en_r <= route_en_nxt;
        end
    end

    assign CELL_ROUTE = cell_sel;
    assign CELL_ROUTE_EN = route_en_r;
    assign WINDOW_CMP_PAUSE = diag2_r[DIAG2_SEL_EN_BIT];
    assign MEAS_RATIO = pinmode_r[NPIN-1:0];
    assign TREF_ENABLE = tref_r;

    // ------------------------------------------------------------
    // channel enables
    // ------------------------------------------------------------
    logic [NCH-1:0] en_vec;

    always_comb begin
        en_vec = '0;
        en_vec[CH_CELL] = route_en_r;
        en_vec[CH_STACK] = chctl1_r[CHCTL1_STACK_BIT];
        for (int p = 0; p < NPIN; p++) begin
            en_vec[int'(CH_PIN1) + p] = chctl1_r[CHCTL1_PIN_LSB + p];
        end
        for (int a = 0; a < 8; a++) begin
            en_vec[INT_A_CH[a]] = inta_r[a];
        end
        for (int b = 0; b < 5; b++) begin
            en_vec[INT_B_CH[b]] = intb_r[b];
        end
    end

    // ------------------------------------------------------------
    // round-robin sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_SEEK, S_WAIT} aucrr_state_e;
    aucrr_state_e state_r, state_nxt;
    logic [CW-1:0] from_r, from_nxt, chan_r, chan_nxt, pick_idx;
    logic start_r, start_nxt, ready_r, ready_nxt, busy_r, busy_nxt;
    logic pick_found, take;

    aucrr_pick #(.N(NCH)) u_pick (
        .en(en_vec),
        .from(from_r),
        .found(pick_found),
        .idx(pick_idx)
    );

    // a result that lands in the cycle of a new start is dropped:
    // the restart aborts the conversion it belonged to
    assign take = (state_r == S_WAIT) && ADC_DONE && !go;

    always_comb begin
        state_nxt = state_r;
        from_nxt = from_r;
        chan_nxt = chan_r;
        start_nxt = 1'b0;
        ready_nxt = ready_r;
        case (state_r)
            S_IDLE: ;
            S_SEEK: begin
                if (pick_found) begin
                    chan_nxt = pick_idx;
                    start_nxt = 1'b1;
                    state_nxt = S_WAIT;
                end else begin
                    ready_nxt = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            S_WAIT: begin
                if (ADC_DONE) begin
                    from_nxt = chan_r + 5'h01;
                    state_nxt = S_SEEK;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
        // a start, even mid-sequence, restarts from the first channel
        if (go) begin
            state_nxt = S_SEEK;
            from_nxt = '0;
            start_nxt = 1'b0;
            ready_nxt = 1'b0;
        end
        busy_nxt = (state_nxt != S_IDLE);
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            from_r <= '0;
            chan_r <= '0;
            start_r <= 1'b0;
            ready_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            from_r <= from_nxt;
            chan_r <= chan_nxt;
            start_r <= start_nxt;
            ready_r <= ready_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign ADC_START = start_r;
    assign ADC_CHAN = chan_r;
    assign AUX_BUSY = busy_r;
    assign AUX_READY = ready_r;

    // ------------------------------------------------------------
    // result storage
    // ------------------------------------------------------------
    // codes are stored as delivered: scaling, the halved threshold
    // references and any range judgement stay with the host
    logic [7:0] cor_hi [NCH];
    logic [7:0] cor_lo [NCH];
    logic [7:0] unc_hi [2];
    logic [15:0] unc_lo [2];
    logic [NCH-1:0] cor_hrd;
    logic [1:0] unc_hrd;
    logic [23:0] pin1_raw;

    for (genvar g = 0; g < NCH; g++) begin : g_cor
        aucrr_slot #(.NB(2)) u_slot (
            .clk(CLK),
            .rst_n(rst_n),
            .wr(take && (chan_r == CW'(g))),
            .din(ADC_RES.corr),
            .hi_rd(cor_hrd[g]),
            .hi(cor_hi[g]),
            .lo(cor_lo[g])
        );
    end

    // filtered data replaces raw data on pin one when selected
    assign pin1_raw = diag4_r[DIAG4_FILT_BIT] ? ADC_RES.filt
        : ADC_RES.raw;

    aucrr_slot #(.NB(3)) u_stack_raw (
        .clk(CLK),
        .rst_n(rst_n),
        .wr(take && (chan_r == CH_STACK)),
        .din(ADC_RES.raw),
        .hi_rd(unc_hrd[0]),
        .hi(unc_hi[0]),
        .lo(unc_lo[0])
    );

    aucrr_slot #(.NB(3)) u_pin1_raw (
        .clk(CLK),
        .rst_n(rst_n),
        .wr(take && (chan_r == CH_PIN1)),
        .din(pin1_raw),
        .hi_rd(unc_hrd[1]),
        .hi(unc_hi[1]),
        .lo(unc_lo[1])
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rdata_r, rdata_nxt;

    // a high-byte read locks the lower bytes only when the value is
    // real, so a busy-time read leaves the shadows alone
    always_comb begin
        rdata_nxt = 8'h00;
        cor_hrd = '0;
        unc_hrd = '0;
        if (BUS.rd) begin
            case (BUS.addr)
                ADDR_CHCTL1: rdata_nxt = chctl1_r;
                ADDR_CTRL: rdata_nxt = {6'h00, tref_r, 1'b0};
                ADDR_DIAG2: rdata_nxt = diag2_r;
                ADDR_DIAG4: rdata_nxt = diag4_r;
                ADDR_PINMODE: rdata_nxt = pinmode_r;
                ADDR_STATUS: rdata_nxt = {6'h00, ready_r, busy_r};
                ADDR_TWOFS: rdata_nxt = TWARN_OFFSET;
                ADDR_INTEN_A: rdata_nxt = inta_r;
                ADDR_INTEN_B: rdata_nxt = intb_r;
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (BUS.addr == ADDR_RES_BASE + 8'(2 * i)) begin
                    rdata_nxt = busy_r ? DIAG_HI : cor_hi[i];
                    cor_hrd[i] = !busy_r;
                end
                if (BUS.addr == ADDR_RES_BASE + 8'(2 * i + 1)) begin
                    rdata_nxt = busy_r ? DIAG_LO : cor_lo[i];
                end
            end
            for (int u = 0; u < 2; u++) begin
                if (BUS.addr == ADDR_UNC_BASE + 8'(3 * u)) begin
                    rdata_nxt = busy_r ? DIAG_HI : unc_hi[u];
                    unc_hrd[u] = !busy_r;
                end
                if (BUS.addr == ADDR_UNC_BASE + 8'(3 * u + 1)) begin
                    rdata_nxt = busy_r ? DIAG_LO : unc_lo[u][15:8];
                end
                if (BUS.addr == ADDR_UNC_BASE + 8'(3 * u + 2)) begin
                    rdata_nxt = busy_r ? DIAG_LO : unc_lo[u][7:0];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    a_ready_after_all: assert property ($rose(ready_r) |->
        $past(state_r == S_SEEK) && !pick_found && !busy_r)
        else $error("ready raised before all channels stored");
    a_busy_diag_read: assert property (BUS.rd && busy_r
        && BUS.addr == ADDR_RES_BASE |=> RDATA == DIAG_HI)
        else $error("result read while busy not diagnostic");
    a_lock_holds: assert property (!$past(unc_hrd[1]) |->
        $stable(unc_lo[1]))
        else $error("locked low bytes changed without high read");
    a_start_enabled: assert property (ADC_START |->
        $past(en_vec[chan_nxt]) && en_vec[ADC_CHAN])
        else $error("conversion started on disabled channel");
    a_cell_range: assert property (ADC_START && ADC_CHAN == CH_CELL
        |-> diag2_r[DIAG2_SEL_EN_BIT] && cell_sel inside {[1:6]})
        else $error("cell converted without valid selection");
    a_go_restart: assert property (go |=> state_r == S_SEEK
        && from_r == 5'h00 && !AUX_READY ##1 (ADC_START || AUX_READY))
        else $error("start did not restart the sequence");
    a_filter_path: assert property (take && chan_r == CH_PIN1
        && diag4_r[DIAG4_FILT_BIT]
        |=> unc_hi[1] == $past(ADC_RES.filt[23:16]))
        else $error("filtered data missing from pin one raw");
    a_suspend_cmp: assert property (BUS.wr && BUS.addr == ADDR_DIAG2
        |=> WINDOW_CMP_PAUSE == $past(BUS.wdata[DIAG2_SEL_EN_BIT]))
        else $error("comparator pause does not follow select enable");
    a_ratio_mode: assert property (BUS.wr && BUS.addr == ADDR_PINMODE
        |=> MEAS_RATIO == $past(BUS.wdata[5:0]))
        else $error("pin mode not applied");

    c_full_run: cover property (go ##[1:200] $rose(ready_r));
    c_restart: cover property (state_r == S_WAIT && go);
    c_locked_read: cover property (unc_hrd[1] ##[1:20] take);
endmodule
`default_nettype wire

/* test/aucrr_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// converter model: answers each start after dly+1 cycles
module aucrr_adc_model
    import aucrr_pkg::*;
(
    input wire logic clk,
    input wire logic start,
    input wire logic [CW-1:0] chan,
    input wire logic [3:0] dly,
    input wire logic [7:0] tag,
    output logic done,
    output var aucrr_adc_s res
);
    logic [CW-1:0] ch = '0;
    logic [4:0] cnt = 5'h00;
    initial done = 1'b0;
    initial res = '0;
    // result only valid with done; it toggles otherwise so stale data shows
    always @(posedge clk) begin
        done <= 1'b0;
        res <= ~res;
        if (start) begin
            ch <= chan;
            cnt <= {1'b0, dly} + 5'h01;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
            if (cnt == 5'h01) begin
                done <= 1'b1;
                // corrected code carries the channel in its high byte and the tag below
                res <= {3'h0, ch, tag, tag, 3'h0, ch, 8'h5a,
                        8'ha5, 3'h0, ch, tag};
            end
        end
    end
endmodule
`default_nettype wire

/* test/aucrr_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module aucrr_top_test
    import aucrr_pkg::*;
;
    localparam logic [7:0] TWOFS = 8'h3c; // arbitrary offset value
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    aucrr_bus_s bus = '0;
    logic [7:0] rdata;
    logic adc_start, adc_done, route_en, suspend, tref, busy, ready;
    logic [CW-1:0] adc_chan;
    aucrr_adc_s adc_res;
    logic [2:0] route;
    logic [NPIN-1:0] ratio;
    logic [3:0] dly = 4'h0;
    logic [7:0] tag = 8'h00;
    logic [CW-1:0] log [$];
    int err_total = 0;
    int compares = 0;
    int ndone = 0;

    always #20 CLK = ~CLK;

    aucrr_top #(.TWARN_OFFSET(TWOFS)) uut (.CLK(CLK), .RESETN(RESETN),
        .BUS(bus), .RDATA(rdata), .ADC_START(adc_start),
        .ADC_CHAN(adc_chan), .ADC_DONE(adc_done), .ADC_RES(adc_res),
        .CELL_ROUTE(route), .CELL_ROUTE_EN(route_en),
        .WINDOW_CMP_PAUSE(suspend), .MEAS_RATIO(ratio), .TREF_ENABLE(tref),
        .AUX_BUSY(busy), .AUX_READY(ready));

    aucrr_adc_model adc (.clk(CLK), .start(adc_start), .chan(adc_chan),
        .dly(dly), .tag(tag), .done(adc_done), .res(adc_res));

    // record the channel order and count the answers
    always @(posedge CLK) begin
        if (adc_start === 1'b1) log.push_back(adc_chan);
        if (adc_done === 1'b1) ndone++;
    end

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge CLK);
        bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge CLK);
        bus <= '0;
        @(negedge CLK);
        chk(rdata, e);
    endtask

    // go with the thermistor reference kept on, then wait for ready
    task automatic go_wait();
        int n;
        log.delete();
        ndone = 0;
        wr(ADDR_CTRL, 8'h03);
        n = 0;
        @(negedge CLK);
        while (ready !== 1'b1 && n < 400) begin
            @(negedge CLK);
            n++;
        end
        chk(8'(ndone), 8'(log.size()));
        if (n >= 400) chk(8'h00, 8'h01);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk(ADDR_STATUS, 8'h00);
        rchk(ADDR_RES_BASE, DIAG_HI);
        rchk(ADDR_RES_BASE + 8'h01, DIAG_LO);
        rchk(ADDR_TWOFS, TWOFS);
        rchk(8'hff, 8'h00);
        chk({7'h0, tref}, 8'h00);
    endtask

    task automatic t_order();
        logic [CW-1:0] e [6] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h07, 5'h14};
        tag = 8'h11;
        wr(ADDR_CHCTL1, 8'h0b);
        wr(ADDR_INTEN_A, 8'h05);
        wr(ADDR_INTEN_B, 8'h10);
        go_wait();
        chk(8'(log.size()), 8'h06);
        foreach (e[i]) chk({3'h0, log[i]}, {3'h0, e[i]});
        rchk(ADDR_STATUS, 8'h02);
        rchk(8'h22, 8'h01);
        rchk(8'h23, 8'h11);
        rchk(8'h28, 8'h04);
        rchk(8'h29, 8'h11);
        rchk(8'h48, 8'h14);
        rchk(8'h49, 8'h11);
        rchk(8'h2c, DIAG_HI);
        rchk(8'h60, 8'h11);
        rchk(8'h61, 8'h01);
        rchk(8'h62, 8'h5a);
        rchk(8'h63, 8'h11);
        rchk(8'h64, 8'h05);
        rchk(8'h65, 8'h5a);
    endtask

    task automatic t_filter();
        tag = 8'h22;
        wr(ADDR_DIAG4, 8'h01);
        go_wait();
        rchk(8'h63, 8'ha5);
        rchk(8'h64, 8'h05);
        rchk(8'h65, 8'h22);
        wr(ADDR_DIAG4, 8'h00);
    endtask

    // high byte first freezes the low byte across a new conversion
    task automatic t_lock();
        rchk(8'h22, 8'h01);
        tag = 8'h33;
        go_wait();
        rchk(8'h23, 8'h22);
        rchk(8'h22, 8'h01);
        rchk(8'h23, 8'h33);
    endtask

    // slow converter: reads while busy, then a restart mid-run
    task automatic t_busy();
        dly = 4'h8;
        wr(ADDR_CTRL, 8'h03);
        rchk(8'h20, DIAG_HI);
        rchk(8'h23, DIAG_LO);
        rchk(8'h63, DIAG_HI);
        chk({7'h0, busy}, 8'h01);
        go_wait();
        chk({3'h0, log[0]}, {3'h0, CH_STACK});
        dly = 4'h0;
    endtask

    task automatic t_cell();
        tag = 8'h44;
        wr(ADDR_DIAG2, 8'h00);
        wr(ADDR_DIAG2, 8'h03);
        wr(ADDR_DIAG2, 8'h0b);
        @(negedge CLK);
        chk({3'h0, route, route_en, suspend}, 8'h0f);
        go_wait();
        chk({3'h0, log[0]}, {3'h0, CH_CELL});
        rchk(8'h20, 8'h00);
        rchk(8'h21, 8'h44);
        wr(ADDR_DIAG2, 8'h03);
        @(negedge CLK);
        chk({6'h0, route_en, suspend}, 8'h00);
        wr(ADDR_DIAG2, 8'h07);
        wr(ADDR_DIAG2, 8'h0f);
        @(negedge CLK);
        chk({6'h0, route_en, suspend}, 8'h01);
    endtask

    task automatic t_mode();
        wr(ADDR_PINMODE, 8'h2a);
        @(negedge CLK);
        chk({2'h0, ratio}, 8'h2a);
        chk({7'h0, tref}, 8'h01);
        wr(ADDR_PINMODE, 8'h15);
        @(negedge CLK);
        chk({2'h0, ratio}, 8'h15);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: far beyond the few hundred cycles the run needs
    initial begin
        #(40 * 20000);
        err_total++;
        results();
    end

    initial begin
        repeat (8) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CLK);
        t_reset();
        t_order();
        t_filter();
        t_lock();
        t_busy();
        t_cell();
        t_mode();
        results();
    end
endmodule
`default_nettype wire
